// ### hdl/tppri_top.sv
// Transmit payload pointer generation and path defect code insertion
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// (R1) Basic mode: consequential defect held 20 frames
// (R2) Enhanced hold: last valid code over idle
// (R3) Hold off: defect code follows alarms at once
// (R4) Basic mode: only G1 bit 5 written
// (R5) Enhanced mode: G1 bits 7..5 form code
// (R6) Source clear: bits 6,7 from label bits
// (R7) Source set: code from automatic code setting
// (R8) Positive request edge: one positive justification
// (R9) Negative request edge: one negative justification
// (R10) Continuous flag: programmed pattern, else 0110
// (R11) Load: first frame programmed flag pattern
// (R12) Load bit self-clears after pointer load
// (R13) Out-of-range load sent; timing keeps last valid
// (R14) Stuff spacing: at most one per four frames
// (R15) Force: arbitrary value in H1/H2, payload normal
// (R16) Force always yields at least one corrupted pointer
// (R17) Current pointer readable, tracks loads and stuffs
// (R18) Size bits placed in every pointer
// (R19) Software re-reads current pointer until stable
// (R20) Software writes zero to reserved bits
// (R21) Pointer changes only at frame pointer bytes
module tppri_top
   import tppri_pkg::*;
#(
   parameter int FRAME_LEN = FRAME_LEN_DEF,  // Bytes per frame
   parameter int H1_POS    = H1_POS_DEF,     // Position of the pointer H1 byte
   parameter int G1_POS    = G1_POS_DEF      // Position of the path status byte
)
(
   input  wire logic        clk_i,           // 40 MHz clock
   input  wire logic        rst_i,           // Synchronous reset, active high
   input  wire logic        wb_cyc_i,        // Wishbone cycle
   input  wire logic        wb_stb_i,        // Wishbone strobe
   input  wire logic        wb_we_i,         // Wishbone write enable
   input  wire logic [31:0] wb_adr_i,        // Wishbone byte address
   input  wire logic [3:0]  wb_sel_i,        // Wishbone byte selects
   input  wire logic [31:0] wb_dat_i,        // Wishbone write data
   output logic      [31:0] wb_dat_o,        // Wishbone read data
   output logic             wb_ack_o,        // Wishbone acknowledge
   input  wire logic [7:0]  payload_i,       // Upstream byte for this position
   input  wire logic        rx_alarm_i,      // Consequential defect from receiver
   output logic      [7:0]  tx_stream_out_o, // Outgoing byte stream
   output logic             frame_start_o,   // High with the first byte of a frame
   output logic      [9:0]  spe_pointer_o    // Pointer used for payload timing
);

   localparam int H2_POS = H1_POS + H1_H2_GAP;

   ////////////////////////////////////////////////////////////////////////////
   // Register bus

   logic [31:0] dat_q;
   logic        ack_q;
   logic [7:0]  idx;
   logic        wr_en;
   logic        wr_ptr_ctrl;
   logic [7:0]  wbyte;

   logic [7:0]  path_ctrl_q;
   logic [7:0]  ptr_ctrl_q;     // Plain bits; request bits live in submodules
   logic [7:0]  force_lo_q;
   logic [7:0]  force_hi_q;
   logic [7:0]  path_status_q;
   logic [2:0]  auto_code_q;
   logic        load_q;
   logic        pos_bit;
   logic        neg_bit;
   logic        pos_done;
   logic        neg_done;
   logic        load_done;
   logic [9:0]  cur_ptr_q;
   logic [7:0]  rd_byte;

   assign idx         = wb_adr_i[9:2];
   assign wbyte       = wb_dat_i[7:0];
   // A write commits on the edge where the master sees ack high
   assign wr_en       = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
   assign wr_ptr_ctrl = wr_en && (idx == IDX_PTR_CTRL);

   always_comb
   begin
      rd_byte = 8'h00;
      unique case (idx)
         IDX_PATH_CTRL:    rd_byte = path_ctrl_q;
         IDX_PTR_CTRL:     rd_byte = {ptr_ctrl_q[7:5], load_q, ptr_ctrl_q[3], neg_bit, pos_bit, ptr_ctrl_q[0]};
         IDX_CUR_PTR_LO:   rd_byte = cur_ptr_q[7:0];                         // R17
         IDX_CUR_PTR_HI:   rd_byte = {6'h00, cur_ptr_q[9:8]};                // R17
         IDX_FORCE_PTR_LO: rd_byte = force_lo_q;
         IDX_FORCE_PTR_HI: rd_byte = force_hi_q;
         IDX_PATH_STATUS:  rd_byte = path_status_q;
         IDX_AUTO_CODE:    rd_byte = {5'h00, auto_code_q};
         default:          rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
         if (wb_cyc_i && wb_stb_i && !ack_q)
            dat_q <= {24'h00_0000, rd_byte};
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         path_ctrl_q   <= RST_PATH_CTRL;
         ptr_ctrl_q    <= RST_PTR_CTRL;
         force_lo_q    <= RST_FORCE_PTR_LO;
         force_hi_q    <= RST_FORCE_PTR_HI;
         path_status_q <= RST_PATH_STATUS;
         auto_code_q   <= RST_AUTO_CODE;
      end
      else if (wr_en)
      begin
         unique case (idx)
            IDX_PATH_CTRL:    path_ctrl_q   <= wbyte;
            IDX_PTR_CTRL:     ptr_ctrl_q    <= wbyte;
            IDX_FORCE_PTR_LO: force_lo_q    <= wbyte;
            IDX_FORCE_PTR_HI: force_hi_q    <= wbyte;
            IDX_PATH_STATUS:  path_status_q <= wbyte;
            IDX_AUTO_CODE:    auto_code_q   <= wbyte[2:0];
            default:          ;
         endcase
      end
   end

   // Load bit: a write of one sets it, hardware clears it; a set wins
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         load_q <= 1'b0;
      else if (wr_ptr_ctrl && wbyte[BIT_PTR_LOAD])
         load_q <= 1'b1;
      else if (wr_ptr_ctrl || load_done)
         load_q <= 1'b0;                                                     // R12
   end

   tppri_req_bit u_pos_req
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .wr_i    (wr_ptr_ctrl),
      .wdata_i (wbyte[BIT_POS_REQ]),
      .done_i  (pos_done),
      .bit_o   (pos_bit)
   );

   tppri_req_bit u_neg_req
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .wr_i    (wr_ptr_ctrl),
      .wdata_i (wbyte[BIT_NEG_REQ]),
      .done_i  (neg_done),
      .bit_o   (neg_bit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Frame position

   logic [13:0] fpos_q;
   logic        at_start;

   assign at_start = (fpos_q == 14'h0000);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         fpos_q <= 14'h0000;
      else if (fpos_q == 14'(FRAME_LEN - 1))
         fpos_q <= 14'h0000;
      else
         fpos_q <= fpos_q + 14'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pointer generation, decided once per frame at its first byte

   logic [9:0]  force_val;
   logic [9:0]  valid_ptr_q;     // Payload timing pointer
   logic [9:0]  word_ptr_q;      // Value placed in H1/H2 this frame
   logic [3:0]  word_ndf_q;
   logic [1:0]  gap_q;
   logic        force_seen_q;
   logic        stuff_ok;
   tppri_kind_e kind_q;
   logic [9:0]  inc_ptr;
   logic [9:0]  dec_ptr;
   logic [9:0]  tx_ptr;
   logic [15:0] ptr_word;

   assign force_val = {force_hi_q[1:0], force_lo_q};
   assign stuff_ok  = !ptr_ctrl_q[BIT_STUFF_SP] || (gap_q == SPACING_GAP);  // R14
   assign inc_ptr   = (valid_ptr_q == PTR_MAX) ? 10'h000 : valid_ptr_q + 10'h001;
   assign dec_ptr   = (valid_ptr_q == 10'h000) ? PTR_MAX : valid_ptr_q - 10'h001;
   assign load_done = at_start && load_q;
   assign pos_done  = at_start && !load_q && pos_bit && stuff_ok;           // R8
   assign neg_done  = at_start && !load_q && !pos_bit && neg_bit && stuff_ok; // R9

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         valid_ptr_q <= 10'h000;
         cur_ptr_q   <= 10'h000;
         word_ptr_q  <= 10'h000;
         word_ndf_q  <= NDF_NORMAL;
         kind_q      <= FK_NORMAL;
         gap_q       <= SPACING_GAP;
      end
      else if (at_start)                                                     // R21
      begin
         kind_q     <= FK_NORMAL;
         word_ndf_q <= ptr_ctrl_q[BIT_NDF_CONT] ? force_hi_q[7:4] : NDF_NORMAL; // R10
         word_ptr_q <= (ptr_ctrl_q[BIT_FORCE_PTR] || force_seen_q) ? force_val : cur_ptr_q; // R15
         if (gap_q != SPACING_GAP)
            gap_q <= gap_q + 2'h1;
         if (load_done)
         begin
            cur_ptr_q  <= force_val;                                         // R17
            word_ptr_q <= force_val;                                         // R13
            word_ndf_q <= force_hi_q[7:4];                                   // R11
            if (force_val <= PTR_MAX)
               valid_ptr_q <= force_val;                                     // R13
         end
         else if (pos_done)
         begin
            kind_q      <= FK_INC;
            valid_ptr_q <= inc_ptr;
            cur_ptr_q   <= inc_ptr;                                          // R17
            gap_q       <= 2'h0;
         end
         else if (neg_done)
         begin
            kind_q      <= FK_DEC;
            valid_ptr_q <= dec_ptr;
            cur_ptr_q   <= dec_ptr;                                          // R17
            gap_q       <= 2'h0;
         end
      end
   end

   // A brief force pulse still gets one corrupted pointer onto the line
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         force_seen_q <= 1'b0;
      else if (wr_ptr_ctrl && wbyte[BIT_FORCE_PTR])
         force_seen_q <= 1'b1;                                               // R16
      else if (at_start)
         force_seen_q <= 1'b0;
   end

   // The stuff frame carries the old value with I or D bits inverted
   always_comb
   begin
      tx_ptr = word_ptr_q;
      unique case (kind_q)
         FK_NORMAL: tx_ptr = word_ptr_q;
         FK_INC:    tx_ptr = word_ptr_q ^ INC_MASK;                          // R8
         FK_DEC:    tx_ptr = word_ptr_q ^ DEC_MASK;                          // R9
      endcase
   end

   assign ptr_word = {word_ndf_q, force_hi_q[3:2], tx_ptr};                  // R18

   ////////////////////////////////////////////////////////////////////////////
   // Path status defect code, evaluated once per frame at the G1 byte

   logic       enh_en;
   logic       src_sel;
   logic       hold_en;
   logic       basic_bit;
   logic [2:0] raw_code;      // {bit5, bit6, bit7}
   logic [2:0] send_code;
   logic       code_idle;
   logic [2:0] last_code_q;
   logic [4:0] hold_q;
   logic       hold_bit;

   assign enh_en    = path_ctrl_q[BIT_ENH_MODE_EN];
   assign src_sel   = path_ctrl_q[BIT_ENH_SRC_SEL];
   assign hold_en   = path_ctrl_q[BIT_HOLD_EN];
   assign basic_bit = path_status_q[BIT_PRDI_SW] || rx_alarm_i;
   assign code_idle = (raw_code == CODE_IDLE_A) || (raw_code == CODE_IDLE_B) || (raw_code == CODE_IDLE_C);
   assign hold_bit  = hold_en && (hold_q != 5'h00);

   always_comb
   begin
      if (src_sel)
         raw_code = rx_alarm_i ? auto_code_q : CODE_SRC_IDLE;                // R7
      else
         raw_code = {basic_bit, path_status_q[0], path_status_q[1]};         // R6
      if (!hold_en)
         send_code = raw_code;                                               // R3
      else if (code_idle && hold_q != 5'h00)
         send_code = last_code_q;                                            // R2
      else
         send_code = raw_code;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hold_q      <= 5'h00;
         last_code_q <= CODE_IDLE_A;
      end
      else if (fpos_q == 14'(G1_POS))
      begin
         if (!hold_en)
            hold_q <= 5'h00;                                                 // R3
         else if (enh_en && !code_idle)
         begin
            hold_q      <= HOLD_FRAMES - 5'h01;                              // R2
            last_code_q <= raw_code;
         end
         else if (!enh_en && rx_alarm_i)
            hold_q <= HOLD_FRAMES - 5'h01;                                   // R1
         else if (hold_q != 5'h00)
            hold_q <= hold_q - 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outgoing stream

   logic [7:0] out_q;
   logic       fs_q;
   logic [9:0] spe_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         out_q <= 8'h00;
         fs_q  <= 1'b0;
         spe_q <= 10'h000;
      end
      else
      begin
         fs_q  <= at_start;
         spe_q <= valid_ptr_q;                                               // R13
         out_q <= payload_i;
         if (fpos_q == 14'(H1_POS))
            out_q <= ptr_word[15:8];                                         // R15
         else if (fpos_q == 14'(H2_POS))
            out_q <= ptr_word[7:0];                                          // R15
         else if (fpos_q == 14'(G1_POS))
         begin
            if (enh_en)
               out_q <= {payload_i[7:4], send_code, payload_i[0]};           // R5
            else
               out_q <= {payload_i[7:4], basic_bit || hold_bit, payload_i[2:0]}; // R4
         end
      end
   end

   assign tx_stream_out_o = out_q;
   assign frame_start_o   = fs_q;
   assign spe_pointer_o   = spe_q;

endmodule

`default_nettype wire

// ### hdl/tppri_pkg.sv
// Constants shared by the transmit pointer and defect-code insertion block
package tppri_pkg;

   // Register indices; byte address on the bus is four times the index
   localparam logic [7:0] IDX_PATH_CTRL    = 8'h40;
   localparam logic [7:0] IDX_PTR_CTRL     = 8'h41;
   localparam logic [7:0] IDX_CUR_PTR_LO   = 8'h43;
   localparam logic [7:0] IDX_CUR_PTR_HI   = 8'h44;
   localparam logic [7:0] IDX_FORCE_PTR_LO = 8'h45;
   localparam logic [7:0] IDX_FORCE_PTR_HI = 8'h46;
   localparam logic [7:0] IDX_PATH_STATUS  = 8'h49;
   localparam logic [7:0] IDX_AUTO_CODE    = 8'h92;

   // Path control fields
   localparam int BIT_ENH_MODE_EN = 6;
   localparam int BIT_ENH_SRC_SEL = 5;
   localparam int BIT_HOLD_EN     = 4;

   // Pointer control fields
   localparam int BIT_FORCE_PTR = 6;
   localparam int BIT_STUFF_SP  = 5;
   localparam int BIT_PTR_LOAD  = 4;
   localparam int BIT_NDF_CONT  = 3;
   localparam int BIT_NEG_REQ   = 2;
   localparam int BIT_POS_REQ   = 1;

   // Path status fields
   localparam int BIT_PRDI_SW = 3;

   // Reset values
   localparam logic [7:0] RST_PATH_CTRL    = 8'h00;
   localparam logic [7:0] RST_PTR_CTRL     = 8'h00;
   localparam logic [7:0] RST_FORCE_PTR_LO = 8'h00;
   localparam logic [7:0] RST_FORCE_PTR_HI = 8'h9A;
   localparam logic [7:0] RST_PATH_STATUS  = 8'h00;
   localparam logic [2:0] RST_AUTO_CODE    = 3'h0;

   // Pointer constants
   localparam logic [9:0] PTR_MAX      = 10'h30E;  // 782
   localparam logic [3:0] NDF_NORMAL   = 4'h6;
   localparam logic [9:0] INC_MASK     = 10'h2AA;  // I bits
   localparam logic [9:0] DEC_MASK     = 10'h155;  // D bits
   localparam logic [1:0] SPACING_GAP  = 2'h3;     // Idle frames between stuffs

   // Defect code persistence, in frames
   localparam logic [4:0] HOLD_FRAMES  = 5'h14;    // 20
   localparam logic [2:0] CODE_IDLE_A  = 3'h0;
   localparam logic [2:0] CODE_IDLE_B  = 3'h1;
   localparam logic [2:0] CODE_IDLE_C  = 3'h3;
   localparam logic [2:0] CODE_SRC_IDLE = 3'h1;

   // Frame layout defaults for a concatenated 622 Mbit/s frame
   localparam int FRAME_LEN_DEF = 9720;
   localparam int H1_POS_DEF    = 3240;
   localparam int H1_H2_GAP     = 12;
   localparam int G1_POS_DEF    = 3294;

   typedef enum logic [2:0] {
      FK_NORMAL = 3'b001,
      FK_INC    = 3'b010,
      FK_DEC    = 3'b100
   } tppri_kind_e;

endpackage

// ### hdl/tppri_req_bit.sv
// One software request bit armed on a 0-to-1 write and cleared by hardware
`timescale 1ns/1ps
`default_nettype none

module tppri_req_bit
(
   input  wire logic clk_i,    // System clock
   input  wire logic rst_i,    // Synchronous reset
   input  wire logic wr_i,     // Write strobe for the owning register
   input  wire logic wdata_i,  // Written value of this bit
   input  wire logic done_i,   // Request carried out
   output logic      bit_o     // Register bit, high while pending
);

   logic bit_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         bit_q <= 1'b0;
      else if (wr_i && wdata_i && !bit_q)
         bit_q <= 1'b1;
      else if (wr_i && !wdata_i)
         bit_q <= 1'b0;
      else if (done_i)
         bit_q <= 1'b0;
   end

   assign bit_o = bit_q;

endmodule

`default_nettype wire

// ### sim/tppri_checker_assertions.sv
// Port-level checks on the transmit pointer and defect-code block
`timescale 1ns/1ps
`default_nettype none

module tppri_checker
   import tppri_pkg::*;
#(
   parameter int FRAME_LEN = FRAME_LEN_DEF  // Bytes per frame
)
(
   input wire logic        clk_i,           // Clock
   input wire logic        rst_i,           // Synchronous reset
   input wire logic        wb_cyc_i,        // Bus cycle
   input wire logic        wb_stb_i,        // Bus strobe
   input wire logic        wb_we_i,         // Bus write
   input wire logic [31:0] wb_adr_i,        // Bus address
   input wire logic [3:0]  wb_sel_i,        // Byte selects
   input wire logic [31:0] wb_dat_i,        // Write data
   input wire logic [31:0] wb_dat_o,        // Read data
   input wire logic        wb_ack_o,        // Acknowledge
   input wire logic [7:0]  payload_i,       // Upstream byte
   input wire logic        rx_alarm_i,      // Receive defect
   input wire logic [7:0]  tx_stream_out_o, // Outgoing byte
   input wire logic        frame_start_o,   // Frame marker
   input wire logic [9:0]  spe_pointer_o    // Timing pointer
);
   int   cnt_q;
   logic seen_q;

   ////////////////////////////////////////////////////////////////
   // Cycles since the last frame marker; unchecked until one is seen
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_q  <= 0;
         seen_q <= 1'b0;
      end
      else if (frame_start_o)
      begin
         cnt_q  <= 0;
         seen_q <= 1'b1;
      end
      else
         cnt_q <= cnt_q + 1;
   end

   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no acknowledge one cycle after request");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("acknowledge without request");
   dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   frame_period_a: assert property (seen_q |-> frame_start_o == (cnt_q == FRAME_LEN - 1))
      else $error("frame marker off its period");
   frame_restart_a: assert property ($fell(rst_i) |-> ##[1:2] frame_start_o)
      else $error("no frame marker after reset");
   spe_range_a: assert property (spe_pointer_o <= PTR_MAX)
      else $error("timing pointer out of range");
   spe_change_a: assert property ($changed(spe_pointer_o) |-> frame_start_o || $past(frame_start_o))
      else $error("timing pointer changed inside a frame");
endmodule

bind tppri_top tppri_checker #(.FRAME_LEN(FRAME_LEN)) tppri_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .payload_i(payload_i),
   .rx_alarm_i(rx_alarm_i), .tx_stream_out_o(tx_stream_out_o), .frame_start_o(frame_start_o),
   .spe_pointer_o(spe_pointer_o));

`default_nettype wire

// ### sim/tppri_rx_model.sv
// Downstream receiver model: captures pointer and status bytes of each frame
`timescale 1ns/1ps
`default_nettype none

module tppri_rx_model
#(
   parameter int H1_POS = 10,  // H1 position
   parameter int G1_POS = 40   // G1 position
)
(
   input  wire logic       clk_i,         // Clock
   input  wire logic       rst_i,         // Synchronous reset
   input  wire logic [7:0] stream_i,      // Byte stream
   input  wire logic       frame_start_i, // First byte of a frame
   output logic      [7:0] h1_o,          // H1 of last frame
   output logic      [7:0] h2_o,          // H2 of last frame
   output logic      [7:0] g1_o,          // G1 of last frame
   output logic            done_o         // Pulse when a frame is published
);
   int         pos_q;
   int         idx;
   logic [7:0] h1_q;
   logic [7:0] h2_q;
   logic [7:0] g1_q;

   assign idx = frame_start_i ? 0 : pos_q;

   ////////////////////////////////////////////////////////////////
   // Publishing whole frames only, so the bench never sees a torn pair
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pos_q  <= 0;
         done_o <= 1'b0;
      end
      else
      begin
         pos_q  <= idx + 1;
         done_o <= frame_start_i;
         if (idx == H1_POS)
            h1_q <= stream_i;
         if (idx == H1_POS + 12)
            h2_q <= stream_i;
         if (idx == G1_POS)
            g1_q <= stream_i;
         if (frame_start_i)
         begin
            h1_o <= h1_q;
            h2_o <= h2_q;
            g1_o <= g1_q;
         end
      end
   end
endmodule

`default_nettype wire

// ### sim/tppri_top_tb.sv
// Self-checking bench for the transmit pointer and defect-code block
`timescale 1ns/1ps
`default_nettype none

module tppri_top_tb;
   import tppri_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        we = 1'b0;
   logic [31:0] adr = 32'h0;
   logic [31:0] wd = 32'h0;
   logic [3:0]  sel = 4'hF;
   logic [7:0]  pay = 8'h00;
   logic        alarm = 1'b0;
   logic [31:0] rdat;
   logic        ack;
   logic [7:0]  so, h1, h2, g1, r;
   logic        fs, dn;
   logic [9:0]  spe, ep, p;
   logic [3:0]  f;
   logic [1:0]  s;
   int          n;
   int          n_mismatch = 0;
   int          compares = 0;

   tppri_top #(.FRAME_LEN(64), .H1_POS(10), .G1_POS(40)) tppri_top_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
      .wb_dat_o(rdat), .wb_ack_o(ack), .payload_i(pay), .rx_alarm_i(alarm), .tx_stream_out_o(so),
      .frame_start_o(fs), .spe_pointer_o(spe));
   tppri_rx_model #(.H1_POS(10), .G1_POS(40)) tppri_rx_model_inst (.clk_i(clk_i), .rst_i(rst_i),
      .stream_i(so), .frame_start_i(fs), .h1_o(h1), .h2_o(h2), .g1_o(g1), .done_o(dn));

   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) pay <= 8'($urandom);

   ////////////////////////////////////////////////////////////////
   function automatic logic [15:0] word(input logic [3:0] fl, input logic [1:0] sz, input logic [9:0] pt);
      return {fl, sz, pt};
   endfunction
   function automatic logic [9:0] flip(input logic [9:0] pt, input logic up);
      return up ? (pt ^ INC_MASK) : (pt ^ DEC_MASK);
   endfunction
   function automatic logic [9:0] step(input logic [9:0] pt, input logic up);
      if (up)
         return (pt == PTR_MAX) ? 10'h000 : pt + 10'h001;
      return pt - 10'h001;
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= {22'h0, i, 2'h0};
      wd <= {24'h0, d};
      do @(posedge clk_i); while (ack !== 1'b1 && ++k < 40);
      r = rdat[7:0];
      if (k >= 40)
         n_mismatch++;
      cyc <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] i, input logic [7:0] e);
      bus(1'b0, i, 8'h00);
      chk({8'h0, r}, {8'h0, e});
   endtask
   task automatic fr(input int m);
      int k;
      repeat (m)
      begin
         k = 0;
         do @(posedge clk_i); while (dn !== 1'b1 && ++k < 200);
         n_mismatch += int'(k >= 200);
      end
   endtask
   task automatic final_report();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      #500000;
      n_mismatch++;
      final_report();
   end

   ////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(77));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      sel <= 4'hE;
      bus(1'b1, IDX_PATH_CTRL, 8'hFF);
      sel <= 4'hF;
      rc(IDX_PATH_CTRL, RST_PATH_CTRL);
      rc(IDX_PTR_CTRL, RST_PTR_CTRL);
      rc(IDX_FORCE_PTR_LO, RST_FORCE_PTR_LO);
      rc(IDX_FORCE_PTR_HI, RST_FORCE_PTR_HI);
      bus(1'b1, 8'h50, 8'hFF);
      rc(8'h50, 8'h00);
      bus(1'b1, IDX_CUR_PTR_LO, 8'hFF);
      rc(IDX_CUR_PTR_LO, 8'h00);
      fr(2);
      chk({h1, h2}, word(NDF_NORMAL, RST_FORCE_PTR_HI[3:2], 10'h000));
      // Basic defect bit and hold, then enhanced codes
      alarm <= 1'b1;
      fr(2);
      chk({15'h0, g1[3]}, 16'h0001);
      alarm <= 1'b0;
      fr(2);
      chk({15'h0, g1[3]}, 16'h0000);
      bus(1'b1, IDX_PATH_CTRL, 8'h10);
      alarm <= 1'b1;
      fr(2);
      alarm <= 1'b0;
      n = 0;
      for (int k = 0; k < 25; k++)
      begin
         fr(1);
         if (g1[3] === 1'b1)
            n++;
      end
      chk(16'(n), 16'(HOLD_FRAMES - 5'h01));
      bus(1'b1, IDX_PATH_STATUS, 8'h02);
      bus(1'b1, IDX_PATH_CTRL, 8'h40);
      fr(2);
      chk({13'h0, g1[3:1]}, 16'h0001);
      bus(1'b1, IDX_AUTO_CODE, 8'h06);
      bus(1'b1, IDX_PATH_CTRL, 8'h70);
      alarm <= 1'b1;
      fr(2);
      chk({13'h0, g1[3:1]}, 16'h0006);
      alarm <= 1'b0;
      fr(2);
      chk({13'h0, g1[3:1]}, 16'h0006);
      bus(1'b1, IDX_PATH_CTRL, 8'h00);
      // Loads
      for (int i = 0; i < 3; i++)
      begin
         p = (i == 2) ? PTR_MAX : 10'($urandom_range(782));
         f = 4'($urandom);
         s = 2'($urandom);
         bus(1'b1, IDX_FORCE_PTR_LO, p[7:0]);
         bus(1'b1, IDX_FORCE_PTR_HI, {f, s, p[9:8]});
         fr(1);
         bus(1'b1, IDX_PTR_CTRL, 8'h10);
         fr(2);
         chk({h1, h2}, word(f, s, p));
         rc(IDX_PTR_CTRL, 8'h00);
         rc(IDX_CUR_PTR_LO, p[7:0]);
         rc(IDX_CUR_PTR_HI, {6'h0, p[9:8]});
         fr(1);
         chk({h1, h2}, word(NDF_NORMAL, s, p));
      end
      ep = PTR_MAX;
      bus(1'b1, IDX_PTR_CTRL, 8'h08);
      fr(3);
      chk({h1, h2}, word(f, s, ep));
      bus(1'b1, IDX_PTR_CTRL, 8'h00);
      // Justifications
      for (int i = 0; i < 3; i++)
      begin
         fr(1);
         bus(1'b1, IDX_PTR_CTRL, (i < 2) ? 8'h02 : 8'h04);
         fr(2);
         chk({h1, h2}, word(NDF_NORMAL, s, flip(ep, i < 2)));
         ep = step(ep, i < 2);
         rc(IDX_PTR_CTRL, 8'h00);
         rc(IDX_CUR_PTR_LO, ep[7:0]);
         rc(IDX_CUR_PTR_LO, ep[7:0]);
         fr(1);
         chk({h1, h2}, word(NDF_NORMAL, s, ep));
         chk({6'h0, spe}, {6'h0, ep});
      end
      // Spacing: stuffs four frames apart
      fr(4);
      bus(1'b1, IDX_PTR_CTRL, 8'h22);
      fr(2);
      chk({h1, h2}, word(NDF_NORMAL, s, flip(ep, 1'b1)));
      ep = step(ep, 1'b1);
      bus(1'b1, IDX_PTR_CTRL, 8'h22);
      n = 0;
      for (int k = 1; k <= 6 && n == 0; k++)
      begin
         fr(1);
         if ({h1, h2} === word(NDF_NORMAL, s, flip(ep, 1'b1)))
            n = k;
      end
      chk(16'(n), 16'h0004);
      ep = step(ep, 1'b1);
      // Brief and held forcing
      p = ~ep;
      bus(1'b1, IDX_FORCE_PTR_LO, p[7:0]);
      bus(1'b1, IDX_FORCE_PTR_HI, {NDF_NORMAL, s, p[9:8]});
      bus(1'b1, IDX_PTR_CTRL, 8'h40);
      bus(1'b1, IDX_PTR_CTRL, 8'h00);
      fr(2);
      chk({h1, h2}, word(NDF_NORMAL, s, p));
      fr(1);
      chk({h1, h2}, word(NDF_NORMAL, s, ep));
      bus(1'b1, IDX_PTR_CTRL, 8'h40);
      fr(3);
      chk({h1, h2}, word(NDF_NORMAL, s, p));
      chk({6'h0, spe}, {6'h0, ep});
      bus(1'b1, IDX_PTR_CTRL, 8'h00);
      // Out-of-range load
      p = 10'd800;
      bus(1'b1, IDX_FORCE_PTR_LO, p[7:0]);
      bus(1'b1, IDX_FORCE_PTR_HI, {NDF_NORMAL, s, p[9:8]});
      fr(1);
      bus(1'b1, IDX_PTR_CTRL, 8'h10);
      fr(2);
      chk({h1, h2}, word(NDF_NORMAL, s, p));
      chk({6'h0, spe}, {6'h0, ep});
      final_report();
   end
endmodule

`default_nettype wire
